/* rtl/psp_pkg.sv */
/*
 Constants, types and stage-map decoding for the power stage parallel configuration block.
 Assumes one 125 MHz clock and a command port that delivers decoded serial write commands.
*/
// What this block does
// - Overcurrent on a single stage becomes a fault after persisting about 4 us.
// - Off-state open-load or short-to-ground faults need about 10 us persistence.
// - Off-state diagnosis is masked about 1.4 ms after a high-side stage turns off.
// - High-side a and c hold on about 600 ms after off command during low battery.
// - Write command code 110011 loads the parallel configuration byte.
// - Stages outside any selected group act alone with own command and diagnosis.
// - Grouped stages use an 8 us overcurrent filter instead of the single value.
// - Low-side codes: 00010 pair ab, 00100 ab and cd, 01000 quad, 11100 bcd.
// - High-side codes: 00110 pair ab, 01110 ab and cd, 01010 quad, 10100 bcd.
// - Low-side b commands ab, quad, triple; c commands cd; diagnosis a, c, b.
// - High-side b commands ab, quad, triple; c commands cd; diagnosis a, c, c.
// - Group timing is the fixed 8 us filter; the register only selects which stages are grouped.
package psp_pkg;

	// ====================================================================
	// Timing
	localparam int CLK_NS        = 8;
	localparam int OVC_TIME_NS   = 4000;
	localparam int OVC_GRP_NS    = 8000;
	localparam int OFF_TIME_NS   = 10000;
	localparam int MASK_TIME_US  = 1400;
	localparam int HOLD_TIME_MS  = 600;
	localparam int OVC_CYC       = OVC_TIME_NS / CLK_NS;
	localparam int OVC_GRP_CYC   = OVC_GRP_NS / CLK_NS;
	localparam int OFF_CYC       = OFF_TIME_NS / CLK_NS;
	localparam int MASK_CYC_DEF  = MASK_TIME_US * 1000 / CLK_NS;
	localparam int HOLD_CYC_DEF  = HOLD_TIME_MS * 1000000 / CLK_NS;

	// ====================================================================
	// Command and register
	localparam logic [5:0] WR_STAGE_CFG = 6'h33;
	localparam logic [7:0] CFG_RESET    = 8'h00;

	// ====================================================================
	// Stage indices and group codes, key is bits {7,3,2,1,0}
	localparam logic [2:0] HS_A = 3'h0;
	localparam logic [2:0] HS_B = 3'h1;
	localparam logic [2:0] HS_C = 3'h2;
	localparam logic [2:0] LS_A = 3'h4;
	localparam logic [2:0] LS_B = 3'h5;
	localparam logic [2:0] LS_C = 3'h6;
	localparam logic [4:0] KEY_LS_AB   = 5'h02;
	localparam logic [4:0] KEY_LS_2P   = 5'h04;
	localparam logic [4:0] KEY_LS_QUAD = 5'h08;
	localparam logic [4:0] KEY_LS_TRI  = 5'h1c;
	localparam logic [4:0] KEY_HS_AB   = 5'h06;
	localparam logic [4:0] KEY_HS_2P   = 5'h0e;
	localparam logic [4:0] KEY_HS_QUAD = 5'h0a;
	localparam logic [4:0] KEY_HS_TRI  = 5'h14;

	typedef struct packed {
		logic [7:0][2:0] src;
		logic [7:0]      diag;
		logic [7:0]      grp;
	} psp_map_type;

	function automatic psp_map_type psp_join(psp_map_type m, logic [7:0] mem,
			logic [2:0] ctl, logic [2:0] dg);
		for (int i = 0; i < 8; i++) begin
			if (mem[i]) begin
				m.src[i]  = ctl;
				m.diag[i] = (3'(i) == dg);
				m.grp[i]  = 1'b1;
			end
		end
		return m;
	endfunction

	// Bits 6..4 are not decoded: combined groupings are outside this block
	function automatic psp_map_type psp_decode(logic [7:0] cfg);
		psp_map_type m;
		for (int i = 0; i < 8; i++) begin
			m.src[i]  = 3'(i);
			m.diag[i] = 1'b1;
			m.grp[i]  = 1'b0;
		end
		case ({cfg[7], cfg[3:0]})
			KEY_LS_AB:   m = psp_join(m, 8'h30, LS_B, LS_A);
			KEY_LS_2P:   m = psp_join(psp_join(m, 8'h30, LS_B, LS_A), 8'hc0, LS_C, LS_C);
			KEY_LS_QUAD: m = psp_join(m, 8'hf0, LS_B, LS_A);
			KEY_LS_TRI:  m = psp_join(m, 8'he0, LS_B, LS_B);
			KEY_HS_AB:   m = psp_join(m, 8'h03, HS_B, HS_A);
			KEY_HS_2P:   m = psp_join(psp_join(m, 8'h03, HS_B, HS_A), 8'h0c, HS_C, HS_C);
			KEY_HS_QUAD: m = psp_join(m, 8'h0f, HS_B, HS_A);
			KEY_HS_TRI:  m = psp_join(m, 8'h0e, HS_B, HS_C);
			default:     m = m;
		endcase
		return m;
	endfunction

endpackage

/* rtl/psp_stage_ctrl.sv */
/*
 Stage grouping, command steering, diagnosis filters, masks and low-battery hold.
 Assumes synchronous inputs; bits 0..3 are high-side a..d, bits 4..7 low-side a..d.
*/
module psp_stage_ctrl #(
	parameter int MASK_CYC = psp_pkg::MASK_CYC_DEF,
	parameter int HOLD_CYC = psp_pkg::HOLD_CYC_DEF
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [5:0] cmd_code_i,
	input  wire logic [7:0] cmd_data_i,
	input  wire logic [7:0] stage_cmd_i,
	input  wire logic [7:0] ovc_cond_i,
	input  wire logic [3:0] off_cond_i,
	input  wire logic       low_batt_i,
	output logic      [7:0] stage_on_o,
	output logic      [7:0] ovc_fault_o,
	output logic      [3:0] off_fault_o
);
	import psp_pkg::*;

	localparam int MW = $clog2(MASK_CYC + 1);
	localparam int HW = $clog2(HOLD_CYC + 1);

	if (MASK_CYC < 2 || HOLD_CYC < 2) $error("psp_stage_ctrl: counts too small");

	// ====================================================================
	// Configuration register
	logic [7:0]  cfg_r, cfg_nxt;
	psp_map_type map;

	always_comb begin
		cfg_nxt = cfg_r;
		if (cmd_valid_i && cmd_code_i == WR_STAGE_CFG) begin
			cfg_nxt = cmd_data_i;
		end
		map = psp_decode(cfg_r);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// ====================================================================
	// Stage state
	logic [7:0]    on_r, on_nxt, ovc_f_r, ovc_f_nxt, eff_cmd, ovc_grp;
	logic [3:0]    off_f_r, off_f_nxt;
	logic [9:0]    ovc_cnt_r [8];
	logic [9:0]    ovc_cnt_nxt [8];
	logic [9:0]    ovc_len [8];
	logic [10:0]   off_cnt_r [4];
	logic [10:0]   off_cnt_nxt [4];
	logic [MW-1:0] mask_r [4];
	logic [MW-1:0] mask_nxt [4];
	logic [HW-1:0] hold_r [2];
	logic [HW-1:0] hold_nxt [2];

	always_comb begin
		on_nxt    = on_r;
		ovc_f_nxt = ovc_f_r;
		off_f_nxt = off_f_r;
		for (int i = 0; i < 8; i++) begin
			// Only the controlling stage's command reaches a member
			eff_cmd[i] = stage_cmd_i[map.src[i]];
			ovc_grp[i] = 1'b0;
			for (int j = 0; j < 8; j++) begin
				if (map.src[j] == map.src[i]) begin
					ovc_grp[i] = ovc_grp[i] | ovc_cond_i[j];
				end
			end
			ovc_len[i] = map.grp[i] ? 10'(OVC_GRP_CYC) : 10'(OVC_CYC);
			on_nxt[i] = eff_cmd[i];
		end
		for (int h = 0; h < 2; h++) begin
			// High-side a and c only; the hold restarts on every fresh off command
			hold_nxt[h] = '0;
			if (on_r[2*h] && !eff_cmd[2*h] && low_batt_i) begin
				on_nxt[2*h] = (hold_r[h] != HW'(HOLD_CYC - 1));
				hold_nxt[h] = on_nxt[2*h] ? hold_r[h] + 1'b1 : '0;
			end
		end
		for (int i = 0; i < 8; i++) begin
			ovc_cnt_nxt[i] = '0;
			if (on_r[i] && ovc_grp[i] && map.diag[i]) begin
				ovc_cnt_nxt[i] = (ovc_cnt_r[i] == ovc_len[i] - 1'b1) ? ovc_cnt_r[i]
					: ovc_cnt_r[i] + 1'b1;
			end
			// The switch-off clear always holds: an off stage's filter stays at zero, so no set follows
			if (!on_r[i] || !map.diag[i]) begin
				ovc_f_nxt[i] = 1'b0;
			end
			if (ovc_cnt_nxt[i] == ovc_len[i] - 1'b1) begin
				ovc_f_nxt[i] = map.diag[i];
			end
		end
		for (int i = 0; i < 4; i++) begin
			mask_nxt[i]    = '0;
			off_cnt_nxt[i] = '0;
			if (!on_r[i]) begin
				mask_nxt[i] = (mask_r[i] == MW'(MASK_CYC)) ? mask_r[i] : mask_r[i] + 1'b1;
				if (mask_r[i] == MW'(MASK_CYC) && off_cond_i[i] && map.diag[i]) begin
					off_cnt_nxt[i] = (off_cnt_r[i] == 11'(OFF_CYC - 1)) ? off_cnt_r[i]
						: off_cnt_r[i] + 1'b1;
				end
			end
			if (on_r[i] || !map.diag[i]) begin
				off_f_nxt[i] = 1'b0;
			end
			if (off_cnt_nxt[i] == 11'(OFF_CYC - 1)) begin
				off_f_nxt[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			on_r    <= 8'h00;
			ovc_f_r <= 8'h00;
			off_f_r <= 4'h0;
			for (int i = 0; i < 8; i++) begin
				ovc_cnt_r[i] <= '0;
			end
			for (int i = 0; i < 4; i++) begin
				off_cnt_r[i] <= '0;
				mask_r[i]    <= '0;
			end
			for (int h = 0; h < 2; h++) begin
				hold_r[h] <= '0;
			end
		end else begin
			on_r      <= on_nxt;
			ovc_f_r   <= ovc_f_nxt;
			off_f_r   <= off_f_nxt;
			ovc_cnt_r <= ovc_cnt_nxt;
			off_cnt_r <= off_cnt_nxt;
			mask_r    <= mask_nxt;
			hold_r    <= hold_nxt;
		end
	end

	assign stage_on_o  = on_r;
	assign ovc_fault_o = ovc_f_r;
	assign off_fault_o = off_f_r;

	// ====================================================================
	// Assertions
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Configuration register and stage map
	cfg_write_a: assert property (cmd_valid_i && cmd_code_i == WR_STAGE_CFG
		|=> cfg_r == $past(cmd_data_i))
		else $error("config not loaded");
	cfg_hold_a: assert property (!(cmd_valid_i && cmd_code_i == WR_STAGE_CFG)
		|=> $stable(cfg_r))
		else $error("config changed without write");
	ls_pair_a: assert property ({cfg_r[7], cfg_r[3:0]} == KEY_LS_AB
		|-> map.src[4] == LS_B && map.diag[4] && !map.diag[5])
		else $error("low-side pair mapped wrong");
	ls_cd_a: assert property ({cfg_r[7], cfg_r[3:0]} == KEY_LS_2P
		|-> eff_cmd[7] == stage_cmd_i[LS_C] && map.diag[6] && !map.diag[7])
		else $error("low-side pair c-d steered wrong");
	hs_tri_a: assert property ({cfg_r[7], cfg_r[3:0]} == KEY_HS_TRI
		|-> map.src[3] == HS_B && map.diag[2] && !map.diag[1] && map.grp[0] == 1'b0)
		else $error("high-side triple mapped wrong");
	hs_cd_a: assert property ({cfg_r[7], cfg_r[3:0]} == KEY_HS_2P
		|-> eff_cmd[3] == stage_cmd_i[HS_C] && map.diag[2] && !map.diag[3])
		else $error("high-side pair c-d steered wrong");

	// Command steering
	ls_follow_a: assert property (1
		|=> on_r[7:4] == $past(eff_cmd[7:4]))
		else $error("low-side stage ignores its controller");
	single_cmd_a: assert property (!map.grp[3]
		|-> eff_cmd[3] == stage_cmd_i[3])
		else $error("single stage not on its own command");
	ls_steer_a: assert property (map.grp[5]
		|-> eff_cmd[5] == stage_cmd_i[LS_B])
		else $error("low-side group not on stage b command");
	hs_steer_a: assert property (map.grp[1]
		|-> eff_cmd[1] == stage_cmd_i[HS_B])
		else $error("high-side group not on stage b command");

	// Filters and masks
	member_quiet_a: assert property (1
		|=> (ovc_f_r & ~$past(map.diag)) == 8'h00)
		else $error("non-diagnosis member reports");
	member_cnt_a: assert property (!map.diag[5]
		|=> ovc_cnt_r[5] == 10'h000)
		else $error("non-diagnosis member filter runs");
	member_off_a: assert property (!map.diag[1]
		|=> !off_f_r[1])
		else $error("non-diagnosis member reports off fault");
	ovc_filter_a: assert property ($rose(ovc_f_r[0])
		|-> $past(ovc_cnt_r[0]) == $past(ovc_len[0]) - 10'h002)
		else $error("overcurrent fault before filter time");
	ovc_clear_a: assert property (!on_r[0]
		|=> !ovc_f_r[0])
		else $error("overcurrent fault kept on a stage that is off");
	ovc_restart_a: assert property (!ovc_grp[0]
		|=> ovc_cnt_r[0] == 10'h000)
		else $error("overcurrent filter not restarted");
	grp_len_a: assert property (map.grp[1]
		|-> ovc_len[1] == 10'(OVC_GRP_CYC))
		else $error("grouped overcurrent filter length wrong");
	mask_start_a: assert property (on_r[2]
		|=> mask_r[2] == MW'(0))
		else $error("off diagnosis mask not restarted");
	off_mask_a: assert property ($rose(off_f_r[2])
		|-> $past(mask_r[2]) == MW'(MASK_CYC)
		&& $past(off_cnt_r[2]) == 11'(OFF_CYC - 2))
		else $error("off diagnosis inside mask or before filter");
	off_restart_a: assert property (!off_cond_i[2]
		|=> off_cnt_r[2] == 11'h000)
		else $error("off-state filter not restarted");
	off_clear_a: assert property (on_r[2]
		|=> !off_f_r[2])
		else $error("off fault kept on a stage that is on");

	// Low-battery hold
	hold_a: assert property ($fell(on_r[0]) && $past(low_batt_i)
		|-> $past(hold_r[0]) == HW'(HOLD_CYC - 1) || !($past(on_r[0]) && !$past(eff_cmd[0])))
		else $error("low-battery hold cut short");
	hold_run_a: assert property (on_r[0] && !eff_cmd[0] && low_batt_i
		&& hold_r[0] != HW'(HOLD_CYC - 1) |=> on_r[0])
		else $error("stage left the low-battery hold early");
	hold_drop_a: assert property (!low_batt_i && !eff_cmd[0]
		|=> !on_r[0])
		else $error("stage held on without low battery");

	hold_c: cover property (on_r[0] && !eff_cmd[0] && low_batt_i ##1 on_r[0]);
	ovc_c: cover property ($rose(ovc_f_r[4]));
	off_c: cover property ($rose(off_f_r[2]));
	quad_c: cover property ({cfg_r[7], cfg_r[3:0]} == KEY_HS_QUAD);
	tri_c: cover property ({cfg_r[7], cfg_r[3:0]} == KEY_LS_TRI);

endmodule

/* verification/psp_ctl_model.sv */
/*
 Controller model: issues configuration write commands to the stage block.
 Assumes the bench calls wr from a process synchronised to clk_i.
*/
module psp_ctl_model (
	input  wire logic       clk_i,
	output logic            cmd_valid_o,
	output logic      [5:0] cmd_code_o,
	output logic      [7:0] cmd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o  = 6'h00;
		cmd_data_o  = 8'h00;
	end
	// ====================================================================
	// Write command
	// Released lines show the inverse, so a stale value never passes
	task automatic wr(input logic [5:0] c, input logic [7:0] d);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o  <= c;
		cmd_data_o  <= d;
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_code_o  <= ~c;
		cmd_data_o  <= ~d;
	endtask
endmodule

/* verification/testbench.sv */
/*
 Self-checking bench for the stage block with a controller model.
 Assumes short mask and hold counts; other counts as the package gives.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import psp_pkg::*;
	localparam int MASK = 200;
	localparam int HOLD = 30;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       cv;
	logic [5:0] cc;
	logic [7:0] cd;
	logic [7:0] scmd  = 8'h00;
	logic [7:0] ovc   = 8'h00;
	logic [3:0] offc  = 4'h0;
	logic       lowb  = 1'b0;
	logic [7:0] on;
	logic [7:0] ovf;
	logic [3:0] offf;
	int         n_errors  = 0;
	int         cmp_count = 0;
	logic [7:0] cfgs [8] = '{8'h02, 8'h04, 8'h08, 8'h8c, 8'h06, 8'h0e, 8'h0a, 8'h84};
	int         ctl  [8] = '{5, 5, 5, 5, 1, 1, 1, 1};
	logic [7:0] exps [8] = '{8'h30, 8'h30, 8'hf0, 8'he0, 8'h03, 8'h03, 8'h0f, 8'h0e};

	always #4 clk_i = ~clk_i;

	psp_ctl_model CTL (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_data_o(cd));
	psp_stage_ctrl #(.MASK_CYC(MASK), .HOLD_CYC(HOLD)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_data_i(cd),
		.stage_cmd_i(scmd), .ovc_cond_i(ovc), .off_cond_i(offc), .low_batt_i(lowb),
		.stage_on_o(on), .ovc_fault_o(ovf), .off_fault_o(offf));

	// ====================================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic drv(input logic [7:0] s, input logic [7:0] o, input logic [3:0] f,
			input logic b);
		@(posedge clk_i);
		scmd <= s;
		ovc  <= o;
		offc <= f;
		lowb <= b;
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ====================================================================
	// Scenarios
	task automatic t_groups();
		for (int i = 0; i < 8; i++) begin
			CTL.wr(WR_STAGE_CFG, cfgs[i]);
			drv(8'h01 << ctl[i], 8'h00, 4'h0, 1'b0);
			step(3);
			chk("group on", on, exps[i]);
			drv(~(8'h01 << ctl[i]), 8'h00, 4'h0, 1'b0);
			step(3);
			chk("members", on, ~(8'h01 << ctl[i]) & ~exps[i]);
		end
		CTL.wr(6'h32, 8'h00);
		drv(8'h02, 8'h00, 4'h0, 1'b0);
		step(3);
		chk("wrong code", on, 8'h0e);
		CTL.wr(WR_STAGE_CFG, 8'h00);
		step(3);
		chk("all single", on, 8'h02);
		$display("test groups done");
	endtask
	task automatic t_ovc();
		drv(8'h01, 8'h01, 4'h0, 1'b0);
		step(400);
		drv(8'h01, 8'h00, 4'h0, 1'b0);
		drv(8'h01, 8'h01, 4'h0, 1'b0);
		step(490);
		chk("ovc restart", ovf, 8'h00);
		step(20);
		chk("ovc single", ovf, 8'h01);
		drv(8'h00, 8'h00, 4'h0, 1'b0);
		CTL.wr(WR_STAGE_CFG, 8'h02);
		drv(8'h20, 8'h20, 4'h0, 1'b0);
		step(700);
		chk("ovc grp early", ovf, 8'h00);
		step(320);
		chk("ovc grp", ovf, 8'h10);
		$display("test overcurrent done");
	endtask
	task automatic t_off();
		drv(8'h04, 8'h00, 4'h0, 1'b0);
		step(3);
		drv(8'h00, 8'h00, 4'h4, 1'b0);
		step(MASK + 1250 - 30);
		chk("off early", {4'h0, offf}, 8'h00);
		step(60);
		chk("off fault", {4'h0, offf}, 8'h04);
		$display("test off-state done");
	endtask
	task automatic t_hold();
		drv(8'h07, 8'h00, 4'h0, 1'b1);
		step(3);
		drv(8'h00, 8'h00, 4'h0, 1'b1);
		step(HOLD - 10);
		chk("hold", on, 8'h05);
		step(15);
		chk("hold end", on, 8'h00);
		drv(8'h05, 8'h00, 4'h0, 1'b1);
		step(3);
		drv(8'h00, 8'h00, 4'h0, 1'b1);
		step(5);
		drv(8'h00, 8'h00, 4'h0, 1'b0);
		step(2);
		chk("hold cut", on, 8'h00);
		$display("test hold done");
	endtask
	task automatic t_reset();
		drv(8'h20, 8'h00, 4'h0, 1'b0);
		step(3);
		chk("pair before reset", on, 8'h30);
		@(posedge clk_i);
		rst_i <= 1'b1;
		step(2);
		chk("reset outputs", on, 8'h00);
		@(posedge clk_i);
		rst_i <= 1'b0;
		step(2);
		chk("reset config", on, 8'h20);
		$display("test reset done");
	endtask

	// ====================================================================
	// Sequence and watchdog
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		step(1);
		t_groups();
		t_ovc();
		t_off();
		t_hold();
		t_reset();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		print_verdict();
	end
endmodule
